/* rtl/blqp_params.svh */
// Offsets, field positions, reset values and widths for the bulk list and done queue pointers.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef BLQP_PARAMS_SVH
`define BLQP_PARAMS_SVH

// Register byte addresses
`define BLQP_BULK_CUR_OFS   8'h2C
`define BLQP_DONE_HEAD_OFS  8'h30
// Unmapped read answer
`define BLQP_UNMAPPED_DATA  32'h00000000
// Pointer reset value, also the end-of-list marker
`define BLQP_PTR_RESET      32'h00000000
// Pointer field position and reserved low bits
`define BLQP_PTR_MSB        31
`define BLQP_PTR_LSB        4
`define BLQP_RSV_BITS       4
// Offset of the link field inside a transfer descriptor
`define BLQP_TD_LINK_OFS    32'h00000008

`endif

/* rtl/blqp_pkg.sv */
// Types shared by the bulk list and done queue pointer block.
// Assumes nothing of its surroundings.
package blqp_pkg;

    // Done queue sequencer states
    typedef enum logic [1:0] {
        DONE_IDLE,
        DONE_LINK,
        DONE_POST
    } blqp_done_e;

endpackage

/* rtl/blqp_ptr_reg.sv */
// Pointer register whose reserved low bits are held at zero.
// Assumes a single load strobe chosen by the parent.
`timescale 1ns/1ps
module blqp_ptr_reg #(
    parameter int W   = 32,
    parameter int RSV = 4
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic         ce,
    input  wire logic         load,
    input  wire logic [W-1:0] loadVal,
    output logic      [W-1:0] ptr
);

    // Stored pointer field
    logic [W-1:0] ptr_reg;

    // Load with reserved bits forced low
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ptr_reg <= '0;
        end else if (ce && load) begin
            ptr_reg <= {loadVal[W-1:RSV], {RSV{1'b0}}};
        end
    end

    assign ptr = ptr_reg;

endmodule

/* rtl/blqp_mem_wr.sv */
// Single-word memory write requester holding address and data until acknowledged.
// Assumes the memory side answers each request with one ack pulse.
`timescale 1ns/1ps
module blqp_mem_wr #(
    parameter int AW = 32,
    parameter int DW = 32
) (
    input  wire logic          mclk,
    input  wire logic          rstn,
    input  wire logic          ce,
    input  wire logic          start,
    input  wire logic [AW-1:0] startAddr,
    input  wire logic [DW-1:0] startData,
    input  wire logic          ack,
    output logic               req,
    output logic      [AW-1:0] addr,
    output logic      [DW-1:0] data
);

    // Request and held word
    logic          req_reg;
    logic [AW-1:0] addr_reg;
    logic [DW-1:0] data_reg;

    // Raise on start, drop on ack
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            req_reg  <= 1'b0;
            addr_reg <= '0;
            data_reg <= '0;
        end else if (ce) begin
            if (start) begin
                req_reg  <= 1'b1;
                addr_reg <= startAddr;
                data_reg <= startData;
            end else if (req_reg && ack) begin
                req_reg <= 1'b0;
            end
        end
    end

    assign req  = req_reg;
    assign addr = addr_reg;
    assign data = data_reg;

endmodule

/* rtl/blqp_core.sv */
// Bulk current-endpoint pointer walk and done queue head management.
// Assumes list-walk events come from the scheduler and memory writes are acked.
`timescale 1ns/1ps
`include "blqp_params.svh"

// Function
// RULE1: advance current pointer after serving descriptor
// RULE2: new frame resumes at current pointer
// RULE3: end of list, flag clear: hold
// RULE4: end of list, flag set: reload, clear
// RULE5: driver writes current pointer only when disabled
// RULE6: reads live value; read-only while enabled
// RULE7: current pointer resets to zero, end
// RULE8: done head holds last completed descriptor
// RULE9: completed descriptor linked to old head first
// RULE10: then done head loads descriptor address
// RULE11: posting head to shared area clears it
// RULE12: head periodically copied to shared area
// RULE13: traversal starts at bulk head pointer
// RULE14: endpoints served round robin, insertion order
// RULE15: reserved low bits read zero, ignore writes
module blqp_core #(
    parameter logic [31:0] TD_LINK_OFS = `BLQP_TD_LINK_OFS
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrEn,
    input  wire logic [31:0] regWrData,
    input  wire logic        regRdEn,
    output logic      [31:0] regRdData,
    input  wire logic        bulkListEnable,
    input  wire logic [31:0] bulkHeadPtr,
    input  wire logic        listFilledFlag,
    output logic             listFilledClear,
    input  wire logic        frameStart,
    input  wire logic        edServed,
    input  wire logic [31:0] edNextPtr,
    output logic             edFetchReq,
    output logic      [31:0] edFetchAddr,
    input  wire logic        tdComplete,
    input  wire logic [31:0] tdAddr,
    input  wire logic        hccaPost,
    input  wire logic [31:0] hccaDoneAddr,
    output logic             doneBusy,
    output logic             memWrReq,
    output logic      [31:0] memWrAddr,
    output logic      [31:0] memWrData,
    input  wire logic        memWrAck
);

    // Pointer values
    logic [31:0]             bulkCur;       // Current bulk endpoint
    logic [31:0]             doneHead;      // Done queue head
    // Output flops
    logic [31:0]             regRdData_reg;
    logic                    listFilledClear_reg;
    logic                    edFetchReq_reg;
    logic [31:0]             edFetchAddr_reg;
    logic                    doneBusy_reg;
    // Done queue sequencer
    blqp_pkg::blqp_done_e    doneState_reg;
    blqp_pkg::blqp_done_e    doneState_next;
    logic [31:0]             pendTd_reg;    // Descriptor being linked
    logic [31:0]             pendTd_next;
    logic                    wrStart;
    logic [31:0]             wrStartAddr;
    logic [31:0]             wrStartData;

    // Address decode
    wire selBulkCur  = (regAddr == `BLQP_BULK_CUR_OFS);
    wire selDoneHead = (regAddr == `BLQP_DONE_HEAD_OFS);

    // List walk events, only while the bulk list runs
    wire servedEv  = bulkListEnable && edServed;
    wire frameEv   = bulkListEnable && frameStart && !edServed;
    wire nextIsEnd = (edNextPtr[`BLQP_PTR_MSB:`BLQP_PTR_LSB] == '0);
    wire curIsEnd  = (bulkCur[`BLQP_PTR_MSB:`BLQP_PTR_LSB] == '0);
    // End of list seen after a served descriptor or at a frame start
    wire endOfList = (servedEv && nextIsEnd) || (frameEv && curIsEnd);
    // RULE4: reload on filled flag
    wire reloadEv  = endOfList && listFilledFlag;
    // RULE1: follow the link of the served descriptor
    wire advanceEv = servedEv && !nextIsEnd;
    // RULE5: software write taken only while list disabled
    wire swBcWr    = regWrEn && selBulkCur && !bulkListEnable;
    wire swHeadWr  = regWrEn && selDoneHead;

    // Current pointer load select
    wire        bcLoad    = reloadEv || advanceEv || swBcWr;
    wire [31:0] bcLoadVal = reloadEv ? bulkHeadPtr : (advanceEv ? edNextPtr : regWrData);

    // RULE2: frame start fetches where the walk stopped
    // RULE13: reload fetches from the head pointer
    wire [31:0] fetchVal  = reloadEv ? bulkHeadPtr : (advanceEv ? edNextPtr : bulkCur);
    wire        fetchEv   = (reloadEv || advanceEv || frameEv)
                            && (fetchVal[`BLQP_PTR_MSB:`BLQP_PTR_LSB] != '0);

    // Done queue head load select
    wire linkDone  = (doneState_reg == blqp_pkg::DONE_LINK) && memWrReq && memWrAck;
    wire postDone  = (doneState_reg == blqp_pkg::DONE_POST) && memWrReq && memWrAck;
    wire        headLoad  = linkDone || postDone || swHeadWr;
    // RULE10: new head is the linked descriptor
    // RULE11: head cleared once posted
    wire [31:0] headVal   = linkDone ? pendTd_reg : (postDone ? `BLQP_PTR_RESET : regWrData);

    // Read mux, unmapped reads answer zero
    // RULE6: live pointer value returned
    wire [31:0] rdVal = selBulkCur ? bulkCur : (selDoneHead ? doneHead : `BLQP_UNMAPPED_DATA);

    // RULE7: current pointer resets to end marker
    // RULE15: reserved bits forced low
    blqp_ptr_reg #(
        .W   (32),
        .RSV (`BLQP_RSV_BITS)
    ) uBulkCur (
        .mclk    (mclk),
        .rstn    (rstn),
        .ce      (ce),
        .load    (bcLoad),
        .loadVal (bcLoadVal),
        .ptr     (bulkCur)
    );

    // RULE8: done head pointer field only
    blqp_ptr_reg #(
        .W   (32),
        .RSV (`BLQP_RSV_BITS)
    ) uDoneHead (
        .mclk    (mclk),
        .rstn    (rstn),
        .ce      (ce),
        .load    (headLoad),
        .loadVal (headVal),
        .ptr     (doneHead)
    );

    // Memory writes for link and post
    blqp_mem_wr #(
        .AW (32),
        .DW (32)
    ) uMemWr (
        .mclk      (mclk),
        .rstn      (rstn),
        .ce        (ce),
        .start     (wrStart),
        .startAddr (wrStartAddr),
        .startData (wrStartData),
        .ack       (memWrAck),
        .req       (memWrReq),
        .addr      (memWrAddr),
        .data      (memWrData)
    );

    // Done queue sequencer next state
    always_comb begin
        doneState_next = doneState_reg;
        pendTd_next    = pendTd_reg;
        wrStart        = 1'b0;
        wrStartAddr    = '0;
        wrStartData    = '0;
        case (doneState_reg)
            // Completion outranks posting
            blqp_pkg::DONE_IDLE: begin
                if (tdComplete) begin
                    // RULE9: old head into descriptor link field
                    doneState_next = blqp_pkg::DONE_LINK;
                    pendTd_next    = {tdAddr[`BLQP_PTR_MSB:`BLQP_PTR_LSB], 4'h0};
                    wrStart        = 1'b1;
                    wrStartAddr    = {tdAddr[`BLQP_PTR_MSB:`BLQP_PTR_LSB], 4'h0} + TD_LINK_OFS;
                    wrStartData    = doneHead;
                end else if (hccaPost) begin
                    // RULE12: copy head to shared area
                    doneState_next = blqp_pkg::DONE_POST;
                    wrStart        = 1'b1;
                    wrStartAddr    = hccaDoneAddr;
                    wrStartData    = doneHead;
                end
            end
            // Wait for link write ack
            blqp_pkg::DONE_LINK: begin
                if (linkDone) begin
                    doneState_next = blqp_pkg::DONE_IDLE;
                end
            end
            // Wait for post write ack
            blqp_pkg::DONE_POST: begin
                if (postDone) begin
                    doneState_next = blqp_pkg::DONE_IDLE;
                end
            end
            default: begin
                doneState_next = blqp_pkg::DONE_IDLE;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            doneState_reg <= blqp_pkg::DONE_IDLE;
            pendTd_reg    <= '0;
            doneBusy_reg  <= 1'b0;
        end else if (ce) begin
            doneState_reg <= doneState_next;
            pendTd_reg    <= pendTd_next;
            doneBusy_reg  <= (doneState_next != blqp_pkg::DONE_IDLE);
        end
    end

    // RULE14: fetch follows list order
    // RULE3: flag clear pulse only on reload
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            edFetchReq_reg      <= 1'b0;
            edFetchAddr_reg     <= '0;
            listFilledClear_reg <= 1'b0;
        end else if (ce) begin
            edFetchReq_reg      <= fetchEv;
            listFilledClear_reg <= reloadEv;
            if (fetchEv) begin
                edFetchAddr_reg <= fetchVal;
            end
        end
    end

    // Registered read data
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            regRdData_reg <= `BLQP_UNMAPPED_DATA;
        end else if (ce && regRdEn) begin
            regRdData_reg <= rdVal;
        end
    end

    assign regRdData       = regRdData_reg;
    assign listFilledClear = listFilledClear_reg;
    assign edFetchReq      = edFetchReq_reg;
    assign edFetchAddr     = edFetchAddr_reg;
    assign doneBusy        = doneBusy_reg;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // Link write issued with old head
    sequence seqLinkIssue;
        ce && tdComplete && (doneState_reg == blqp_pkg::DONE_IDLE);
    endsequence
    sequence seqLinkWrite;
        memWrReq && (memWrData == $past(doneHead))
        && (memWrAddr == {$past(tdAddr[31:4]), 4'h0} + TD_LINK_OFS);
    endsequence

    // Pointer walk checks
    chk_advance_next: assert property ( // RULE1
        ce && advanceEv |=> bulkCur == {$past(edNextPtr[31:4]), 4'h0})
        else $error("current pointer did not advance");
    chk_frame_resume: assert property ( // RULE2
        ce && frameEv && !curIsEnd |=> edFetchReq && edFetchAddr == $past(bulkCur))
        else $error("frame did not resume at current pointer");
    chk_end_hold: assert property ( // RULE3
        ce && endOfList && !listFilledFlag |=> $stable(bulkCur) && !listFilledClear)
        else $error("pointer moved at unfilled end");
    chk_end_quiet: assert property ( // RULE3
        ce && endOfList && !listFilledFlag |=> !edFetchReq)
        else $error("fetch issued at unfilled end");
    chk_end_reload: assert property ( // RULE4
        ce && reloadEv |=> bulkCur == {$past(bulkHeadPtr[31:4]), 4'h0} && listFilledClear)
        else $error("reload from head failed");
    chk_disabled_still: assert property ( // RULE5
        ce && !bulkListEnable && !(regWrEn && selBulkCur) |=> $stable(bulkCur))
        else $error("pointer moved while list disabled");
    chk_ro_enabled: assert property ( // RULE6
        ce && regWrEn && selBulkCur && bulkListEnable && !bcLoad |=> $stable(bulkCur))
        else $error("write taken while list enabled");
    chk_reset_zero: assert property ( // RULE7
        $rose(rstn) |-> bulkCur == '0 && doneHead == '0)
        else $error("pointers not zero after reset");
    chk_reserved_zero: assert property ( // RULE15
        bulkCur[3:0] == 4'h0 && doneHead[3:0] == 4'h0)
        else $error("reserved bits not zero");

    // Done queue checks
    chk_busy_flag: assert property ( // RULE9
        ce && (tdComplete || hccaPost) && (doneState_reg == blqp_pkg::DONE_IDLE) |=> doneBusy && memWrReq)
        else $error("done sequencer did not start");
    chk_link_write: assert property ( // RULE9
        seqLinkIssue |=> seqLinkWrite)
        else $error("link write wrong");
    chk_req_hold: assert property ( // RULE9
        memWrReq && !memWrAck |=> memWrReq && $stable(memWrAddr) && $stable(memWrData))
        else $error("memory write dropped before ack");
    chk_link_load: assert property ( // RULE10
        ce && linkDone |=> doneHead == $past(pendTd_reg) && !doneBusy)
        else $error("done head not loaded with descriptor");
    chk_post_clear: assert property ( // RULE11
        ce && postDone |=> doneHead == '0)
        else $error("done head not cleared after post");
    chk_post_data: assert property ( // RULE12
        ce && hccaPost && !tdComplete && doneState_reg == blqp_pkg::DONE_IDLE
        |=> memWrReq && memWrData == $past(doneHead) && memWrAddr == $past(hccaDoneAddr))
        else $error("post write wrong");

endmodule

/* sim/blqp_mem_model.sv */
// Far-side model: system memory taking link and shared-area writes, plus driver-owned list-filled flag.
// Assumes the requester holds address and data until the ack edge.
`timescale 1ns/1ps
module blqp_mem_model (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        memWrReq,
    input  wire logic [31:0] memWrAddr,
    input  wire logic [31:0] memWrData,
    output logic             memWrAck,
    input  wire logic [3:0]  ackDelay,
    input  wire logic        flagSet,
    input  wire logic        listFilledClear,
    output logic             listFilledFlag,
    output logic      [31:0] lastAddr,
    output logic      [31:0] lastData,
    output logic      [7:0]  wrCount
);
    logic [3:0] waitCnt; // Cycles spent on pending write

    // link write and shared area copy
    // Store one word after ackDelay cycles, ack for one cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            waitCnt  <= 4'h0;
            memWrAck <= 1'b0;
            lastAddr <= 32'h00000000;
            lastData <= 32'h00000000;
            wrCount  <= 8'h00;
        end else begin
            memWrAck <= 1'b0;
            if (memWrReq && !memWrAck) begin
                if (waitCnt >= ackDelay) begin
                    memWrAck <= 1'b1;
                    lastAddr <= memWrAddr;
                    lastData <= memWrData;
                    wrCount  <= wrCount + 8'h01;
                    waitCnt  <= 4'h0;
                end else begin
                    waitCnt <= waitCnt + 4'h1;
                end
            end
        end
    end

    // Flag set by driver, cleared by controller pulse
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            listFilledFlag <= 1'b0;
        end else if (flagSet) begin
            listFilledFlag <= 1'b1;
        end else if (listFilledClear) begin
            listFilledFlag <= 1'b0;
        end
    end
endmodule

/* sim/testbench.sv */
// Self-checking bench for the bulk pointer walk and done queue head.
// Assumes the memory model in blqp_mem_model and the design header on the include path.
`timescale 1ns/1ps
`include "blqp_params.svh"
module testbench;
    logic        mclk           = 1'b0;
    logic        rstn           = 1'b0;
    logic        ce             = 1'b1;
    logic [7:0]  regAddr        = 8'h00;
    logic        regWrEn        = 1'b0;
    logic [31:0] regWrData      = 32'h00000000;
    logic        regRdEn        = 1'b0;
    logic        bulkListEnable = 1'b0;
    logic [31:0] bulkHeadPtr    = 32'h00000000;
    logic        frameStart     = 1'b0;
    logic        edServed       = 1'b0;
    logic [31:0] edNextPtr      = 32'h00000000;
    logic        tdComplete     = 1'b0;
    logic [31:0] tdAddr         = 32'h00000000;
    logic        hccaPost       = 1'b0;
    logic [31:0] hccaDoneAddr   = 32'h00000000;
    logic [3:0]  ackDelay       = 4'h0;
    logic        flagSet        = 1'b0;
    logic [31:0] regRdData, edFetchAddr, memWrAddr, memWrData, lastAddr, lastData;
    logic        listFilledFlag, listFilledClear, edFetchReq, doneBusy, memWrReq, memWrAck;
    logic [7:0]  wrCount;
    int          failCount      = 0;
    int          checks         = 0;

    // Free-running 20 MHz clock
    always #25 mclk = ~mclk;

    blqp_core blqp_core_inst (.mclk(mclk), .rstn(rstn), .ce(ce), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .bulkListEnable(bulkListEnable),
        .bulkHeadPtr(bulkHeadPtr), .listFilledFlag(listFilledFlag), .listFilledClear(listFilledClear),
        .frameStart(frameStart), .edServed(edServed), .edNextPtr(edNextPtr), .edFetchReq(edFetchReq),
        .edFetchAddr(edFetchAddr), .tdComplete(tdComplete), .tdAddr(tdAddr), .hccaPost(hccaPost),
        .hccaDoneAddr(hccaDoneAddr), .doneBusy(doneBusy), .memWrReq(memWrReq), .memWrAddr(memWrAddr),
        .memWrData(memWrData), .memWrAck(memWrAck));

    blqp_mem_model blqp_mem_model_inst (.mclk(mclk), .rstn(rstn), .memWrReq(memWrReq), .memWrAddr(memWrAddr),
        .memWrData(memWrData), .memWrAck(memWrAck), .ackDelay(ackDelay), .flagSet(flagSet),
        .listFilledClear(listFilledClear), .listFilledFlag(listFilledFlag), .lastAddr(lastAddr),
        .lastData(lastData), .wrCount(wrCount));

    // One clock, then the fixed drive delay
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask

    // Compare and count
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            failCount++;
        end
    endtask

    // One-cycle register write
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        regAddr   = a;
        regWrData = d;
        regWrEn   = 1'b1;
        tick();
        regWrEn = 1'b0;
    endtask

    // Read, data lands one edge later
    task automatic regCheck(input logic [7:0] a, input logic [31:0] exp, input string name);
        regAddr = a;
        regRdEn = 1'b1;
        tick();
        regRdEn = 1'b0;
        check(name, exp, regRdData);
    endtask

    // Served descriptor or frame start, then fetch and clear outputs
    task automatic edEvent(input logic srv, input logic [31:0] nxt, input logic expFetch,
                           input logic [31:0] expAddr, input logic expClr);
        edServed   = srv;
        frameStart = !srv;
        edNextPtr  = nxt;
        tick();
        edServed   = 1'b0;
        frameStart = 1'b0;
        check("edFetchReq", 32'(expFetch), 32'(edFetchReq));
        if (expFetch) check("edFetchAddr", expAddr, edFetchAddr);
        check("listFilledClear", 32'(expClr), 32'(listFilledClear));
    endtask

    // Completion or post, memory write checks, optional event while busy
    task automatic doneEvent(input logic td, input logic [31:0] a, input logic [31:0] expAddr,
                             input logic [31:0] expData, input logic intrude);
        tdComplete   = td;
        hccaPost     = !td;
        tdAddr       = a;
        hccaDoneAddr = a;
        tick();
        tdComplete = 1'b0;
        hccaPost   = 1'b0;
        check("memWrReq", 32'h00000001, 32'(memWrReq));
        check("memWrAddr", expAddr, memWrAddr);
        check("memWrData", expData, memWrData);
        check("doneBusy", 32'h00000001, 32'(doneBusy));
        // Completion during busy must be dropped
        if (intrude) begin
            tdComplete = 1'b1;
            tdAddr     = 32'h00006000;
            tick();
            tdComplete = 1'b0;
        end
        for (int i = 0; i < 40 && doneBusy !== 1'b0; i++) tick();
        check("doneBusy idle", 32'h00000000, 32'(doneBusy));
    endtask

    // Counts and verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge mclk);
        $display("BAD watchdog expected finish seen hang");
        failCount++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge mclk);
        #1 rstn = 1'b1;
        tick();
        regCheck(`BLQP_BULK_CUR_OFS, `BLQP_PTR_RESET, "bulkCur reset");
        regCheck(`BLQP_DONE_HEAD_OFS, `BLQP_PTR_RESET, "doneHead reset");
        regCheck(8'h00, `BLQP_UNMAPPED_DATA, "unmapped");
        regWrite(`BLQP_BULK_CUR_OFS, 32'hABCDEF5F);
        regCheck(`BLQP_BULK_CUR_OFS, 32'hABCDEF50, "bulkCur write");
        regWrite(`BLQP_DONE_HEAD_OFS, 32'h12345678);
        regCheck(`BLQP_DONE_HEAD_OFS, 32'h12345670, "doneHead write");
        bulkListEnable = 1'b1;
        regWrite(`BLQP_BULK_CUR_OFS, 32'h11111110);
        regCheck(`BLQP_BULK_CUR_OFS, 32'hABCDEF50, "bulkCur locked");
        edEvent(1'b0, 32'h00000000, 1'b1, 32'hABCDEF50, 1'b0);
        edEvent(1'b1, 32'h00002000, 1'b1, 32'h00002000, 1'b0);
        edEvent(1'b1, 32'h00003000, 1'b1, 32'h00003000, 1'b0);
        regCheck(`BLQP_BULK_CUR_OFS, 32'h00003000, "bulkCur live");
        edEvent(1'b1, 32'h00000000, 1'b0, 32'h00000000, 1'b0);
        regCheck(`BLQP_BULK_CUR_OFS, 32'h00003000, "bulkCur hold");
        bulkHeadPtr = 32'h00001000;
        flagSet     = 1'b1;
        tick();
        flagSet = 1'b0;
        edEvent(1'b1, 32'h00000000, 1'b1, 32'h00001000, 1'b1);
        tick();
        check("listFilledFlag", 32'h00000000, 32'(listFilledFlag));
        regCheck(`BLQP_BULK_CUR_OFS, 32'h00001000, "bulkCur reload");
        doneEvent(1'b1, 32'h0000400C, 32'h00004000 + `BLQP_TD_LINK_OFS, 32'h12345670, 1'b0);
        regCheck(`BLQP_DONE_HEAD_OFS, 32'h00004000, "doneHead link");
        ackDelay = 4'h5;
        doneEvent(1'b1, 32'h00005000, 32'h00005000 + `BLQP_TD_LINK_OFS, 32'h00004000, 1'b1);
        regCheck(`BLQP_DONE_HEAD_OFS, 32'h00005000, "doneHead busy drop");
        check("wrCount", 32'h00000002, 32'(wrCount));
        doneEvent(1'b0, 32'h00000100, 32'h00000100, 32'h00005000, 1'b0);
        check("shared addr", 32'h00000100, lastAddr);
        check("shared data", 32'h00005000, lastData);
        regCheck(`BLQP_DONE_HEAD_OFS, 32'h00000000, "doneHead posted");
        bulkListEnable = 1'b0;
        regWrite(`BLQP_BULK_CUR_OFS, 32'h00008880);
        regWrite(`BLQP_DONE_HEAD_OFS, 32'h00007770);
        // Mid-run reset clears both pointers
        rstn = 1'b0;
        tick();
        rstn = 1'b1;
        tick();
        regCheck(`BLQP_BULK_CUR_OFS, `BLQP_PTR_RESET, "bulkCur rerun");
        regCheck(`BLQP_DONE_HEAD_OFS, `BLQP_PTR_RESET, "doneHead rerun");
        bulkListEnable = 1'b1;
        edEvent(1'b0, 32'h00000000, 1'b0, 32'h00000000, 1'b0);
        // Clock enable low freezes the walk
        ce = 1'b0;
        edEvent(1'b1, 32'h00002000, 1'b0, 32'h00000000, 1'b0);
        ce = 1'b1;
        regCheck(`BLQP_BULK_CUR_OFS, `BLQP_PTR_RESET, "bulkCur frozen");
        summarize();
    end
endmodule
